//--- slf_ctrl.sv
// Top: wake, supply-loss, ground-loss and fail-mode control of the switch.
// Assumes supply monitors arrive as synchronous levels from analog logic.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Awake while wake level high; sleep with channels and external driver off when low.
// - While reset pin low, clock pin reports wake state.
// - Awake and not woken by reset pin: drive clock pin high.
// - Asleep or woken by reset pin: clock pin stays input.
// - Both supplies lost: power off, outputs off, registers and faults cleared.
// - Battery lost, logic supply good: keep state, channels off.
// - Battery lost, logic supply good: external driver follows SPI setting in Normal mode.
// - Battery lost: no wake report on clock pin.
// - Logic supply lost, battery good: SPI unavailable, watchdog timeout.
// - No logic supply: no SPI read data returned.
// - Ground lost: four power channels off.
// - Normal mode: channels follow internal PWM configured by SPI.
// - Faults reported: open load, shorts, overcurrent, temp, clock, voltages.
// - Fail-mode input at one puts device into Fail mode.
// - Fail mode: each channel follows its direct input, no logic supply needed.
// - Status bit shows present fail-mode input level.
// - Fail mode entered only after input high longer than 200 us.
// - Watchdog timeout after 32 ms or 128 ms, chosen by select.
module slf_ctrl
	import slf_pkg::*;
#(
	parameter int unsigned DGL_CYCLES   = DGL_CYC,
	parameter int unsigned WD_SHORT     = WD_SHORT_CYC,
	parameter int unsigned WD_LONG      = WD_LONG_CYC
)
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        clk_en_i,
	// Supply and wake monitors
	input  wire logic        wake_i,
	input  wire logic        bat_above_por_i,
	input  wire logic        vcc_above_por_i,
	input  wire logic        gnd_lost_i,
	// Discrete pins
	input  wire logic        active_low_reset_pin_i,
	input  wire logic        fail_mode_force_input_i,
	input  wire logic [3:0]  direct_channel_inputs_i,
	input  wire logic        clk_pin_i,
	output logic             clk_pin_o,
	output logic             clk_pin_oe_n_o,
	// SPI side
	input  wire logic [3:0]  pwm_ch_i,
	input  wire logic        ext_drv_cfg_i,
	input  wire logic        spi_valid_frame_i,
	input  wire logic        watchdog_period_select_i,
	input  wire logic [7:0]  fault_flags_i,
	input  wire logic        spi_read_req_i,
	input  wire logic [15:0] spi_read_data_i,
	output logic [15:0]      spi_read_data_o,
	output logic             spi_read_valid_o,
	// Outputs and status
	output logic [3:0]       power_channel_outputs_o,
	output logic             external_driver_control_output_o,
	output logic             fail_input_status_bit_o,
	output logic             spi_watchdog_timeout_o,
	output logic [7:0]       fault_report_o,
	output logic [1:0]       mode_o,
	output logic             regs_clear_o
);
	slf_sync_if sy ();

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	slf_in_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.clk_en_i   (clk_en_i),
		.pins_i     ({active_low_reset_pin_i, direct_channel_inputs_i,
		              fail_mode_force_input_i}),
		.sy         (sy)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	slf_mode_e             mode_q, mode_d;
	logic [CNT_W-1:0]      fdg_q, fdg_d;
	logic                  fail_q, fail_d;
	logic [CNT_W-1:0]      cdg_q [NUM_CH];
	logic [CNT_W-1:0]      cdg_d [NUM_CH];
	logic [NUM_CH-1:0]     ich_q, ich_d;
	logic [CNT_W-1:0]      wd_q, wd_d;
	logic                  wdto_q, wdto_d;
	logic                  rst_wake_q, rst_wake_d;
	logic [3:0]            out_q, out_d;
	logic                  ext_q, ext_d;
	logic                  clko_q, clko_d, oen_q, oen_d;
	logic [15:0]           rd_q, rd_d;
	logic                  rdv_q, rdv_d;
	logic [7:0]            flt_q, flt_d;
	logic                  lim_q, lim_d;
	logic                  clr_q, clr_d;

	logic                  pwr_off, bat_loss, vcc_loss;
	logic [CNT_W-1:0]      wd_lim;

	// Saturating deglitch count: true once high longer than limit
	function automatic logic [CNT_W-1:0] dgl_next(input logic lvl,
		input logic [CNT_W-1:0] c);
		if (!lvl)
			dgl_next = '0;
		else if (c < CNT_W'(DGL_CYCLES))
			dgl_next = c + 1'b1;
		else
			dgl_next = c;
	endfunction : dgl_next

	assign pwr_off  = !bat_above_por_i && !vcc_above_por_i;
	assign bat_loss = !bat_above_por_i && vcc_above_por_i;
	assign vcc_loss = bat_above_por_i && !vcc_above_por_i;
	assign wd_lim   = watchdog_period_select_i ? CNT_W'(WD_LONG)
	                                           : CNT_W'(WD_SHORT);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		mode_d     = mode_q;
		fdg_d      = fdg_q;
		fail_d     = fail_q;
		cdg_d      = cdg_q;
		ich_d      = ich_q;
		wd_d       = wd_q;
		wdto_d     = wdto_q;
		rst_wake_d = rst_wake_q;
		out_d      = out_q;
		ext_d      = ext_q;
		clko_d     = clko_q;
		oen_d      = oen_q;
		rd_d       = rd_q;
		rdv_d      = 1'b0;
		flt_d      = flt_q;
		lim_d      = lim_q;
		clr_d      = 1'b0;
		if (pwr_off)
		begin
			mode_d = SLF_OFF;
			fdg_d  = '0;
			fail_d = 1'b0;
			for (int i = 0; i < NUM_CH; i++)
				cdg_d[i] = '0;
			ich_d  = CH_OFF;
			wd_d   = '0;
			wdto_d = 1'b0;
			rst_wake_d = 1'b0;
			out_d  = CH_OFF;
			ext_d  = 1'b0;
			clko_d = 1'b0;
			oen_d  = 1'b1;
			rd_d   = 16'h0000;
			flt_d  = 8'h00;
			lim_d  = 1'b0;
			clr_d  = 1'b1;
		end
		else
		begin
			lim_d = sy.fail_lvl;
			fdg_d = dgl_next(sy.fail_lvl, fdg_q);
			fail_d = (fdg_q >= CNT_W'(DGL_CYCLES)) && sy.fail_lvl;
			for (int i = 0; i < NUM_CH; i++)
			begin
				cdg_d[i] = dgl_next(sy.ch_lvl[i], cdg_q[i]);
				ich_d[i] = (cdg_q[i] >= CNT_W'(DGL_CYCLES)) && sy.ch_lvl[i];
			end
			// Watchdog: valid frames restart it; logic supply loss forces it
			if (vcc_loss)
				wdto_d = 1'b1;
			else if (spi_valid_frame_i)
			begin
				wd_d   = '0;
				wdto_d = 1'b0;
			end
			else if (wd_q >= wd_lim)
				wdto_d = 1'b1;
			else
				wd_d = wd_q + 1'b1;
			flt_d = fault_flags_i;
			// Wake source tracking
			if (!wake_i)
				rst_wake_d = 1'b0;
			else if (mode_q == SLF_SLEEP && sy.rst_n_lvl)
				rst_wake_d = 1'b1;
			// Mode
			if (!wake_i)
				mode_d = SLF_SLEEP;
			else if (fail_q)
				mode_d = SLF_FAIL;
			else
				mode_d = SLF_NORM;
			// Channel outputs
			if (!wake_i || gnd_lost_i || !bat_above_por_i)
				out_d = CH_OFF;
			else if (fail_q)
				out_d = ich_q;
			else
				out_d = pwm_ch_i;
			ext_d = vcc_above_por_i && wake_i && !fail_q && ext_drv_cfg_i;
			// Clock pin wake report
			clko_d = 1'b1;
			oen_d  = !(wake_i && !sy.rst_n_lvl && !rst_wake_q
			         && bat_above_por_i);
			// SPI read data needs logic supply
			if (spi_read_req_i && vcc_above_por_i)
			begin
				rd_d  = spi_read_data_i;
				rdv_d = 1'b1;
			end
			else if (!vcc_above_por_i)
				rd_d = 16'h0000;
		end
		if (!clk_en_i)
		begin
			mode_d = mode_q;
			fdg_d = fdg_q;
			fail_d = fail_q;
			cdg_d = cdg_q;
			ich_d = ich_q;
			wd_d = wd_q;
			wdto_d = wdto_q;
			rst_wake_d = rst_wake_q;
			out_d = out_q;
			ext_d = ext_q;
			clko_d = clko_q;
			oen_d = oen_q;
			rd_d = rd_q;
			rdv_d = rdv_q;
			flt_d = flt_q;
			lim_d = lim_q;
			clr_d = clr_q;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_q     <= SLF_OFF;
			fdg_q      <= '0;
			fail_q     <= 1'b0;
			for (int i = 0; i < NUM_CH; i++)
				cdg_q[i] <= '0;
			ich_q      <= CH_OFF;
			wd_q       <= '0;
			wdto_q     <= 1'b0;
			rst_wake_q <= 1'b0;
			out_q      <= CH_OFF;
			ext_q      <= 1'b0;
			clko_q     <= 1'b0;
			oen_q      <= 1'b1;
			rd_q       <= 16'h0000;
			rdv_q      <= 1'b0;
			flt_q      <= 8'h00;
			lim_q      <= 1'b0;
			clr_q      <= 1'b0;
		end
		else
		begin
			mode_q     <= mode_d;
			fdg_q      <= fdg_d;
			fail_q     <= fail_d;
			cdg_q      <= cdg_d;
			ich_q      <= ich_d;
			wd_q       <= wd_d;
			wdto_q     <= wdto_d;
			rst_wake_q <= rst_wake_d;
			out_q      <= out_d;
			ext_q      <= ext_d;
			clko_q     <= clko_d;
			oen_q      <= oen_d;
			rd_q       <= rd_d;
			rdv_q      <= rdv_d;
			flt_q      <= flt_d;
			lim_q      <= lim_d;
			clr_q      <= clr_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign power_channel_outputs_o          = out_q;
	assign external_driver_control_output_o = ext_q;
	assign clk_pin_o                        = clko_q;
	assign clk_pin_oe_n_o                   = oen_q;
	assign spi_read_data_o                  = rd_q;
	assign spi_read_valid_o                 = rdv_q;
	assign fail_input_status_bit_o          = lim_q;
	assign spi_watchdog_timeout_o           = wdto_q;
	assign fault_report_o                   = flt_q;
	assign mode_o                           = mode_q;
	assign regs_clear_o                     = clr_q;
endmodule : slf_ctrl
`default_nettype wire

//--- slf_pkg.sv
// Package: constants and types of the supply-loss and fail-mode control.
// Assumes a 200 MHz core clock.
`default_nettype none
package slf_pkg;
	localparam int unsigned CLK_MHZ          = 200;
	localparam int unsigned NUM_CH           = 4;
	// Deglitch time for fail-mode and direct inputs, microseconds
	localparam int unsigned DGL_US           = 200;
	localparam int unsigned DGL_CYC          = DGL_US * CLK_MHZ;
	// Watchdog periods, milliseconds
	localparam int unsigned WD_SHORT_MS      = 32;
	localparam int unsigned WD_LONG_MS       = 128;
	localparam int unsigned WD_SHORT_CYC     = WD_SHORT_MS * 1000 * CLK_MHZ;
	localparam int unsigned WD_LONG_CYC      = WD_LONG_MS * 1000 * CLK_MHZ;
	localparam int unsigned CNT_W            = 25;
	localparam logic [NUM_CH-1:0] CH_OFF     = 4'h0;
	localparam int unsigned SYNC_STAGES      = 3;

	typedef enum logic [1:0] {
		SLF_OFF   = 2'b00,
		SLF_SLEEP = 2'b01,
		SLF_NORM  = 2'b11,
		SLF_FAIL  = 2'b10
	} slf_mode_e;
endpackage : slf_pkg
`default_nettype wire

//--- slf_sync_if.sv
// Interface: synchronised pin levels from the input stage.
// Assumes one core clock domain.
`timescale 1ns/10ps
`default_nettype none
interface slf_sync_if;
	logic       fail_lvl;
	logic [3:0] ch_lvl;
	logic       rst_n_lvl;
	modport src (output fail_lvl, output ch_lvl, output rst_n_lvl);
	modport dst (input fail_lvl, input ch_lvl, input rst_n_lvl);
endinterface : slf_sync_if
`default_nettype wire

//--- slf_in_sync.sv
// Three-stage pin synchroniser; a change counts when stages two and three agree.
// Assumes pins are asynchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module slf_in_sync
	import slf_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        clk_en_i,
	// Raw pins
	input  wire logic [5:0]  pins_i,
	// Synchronised levels
	slf_sync_if.src          sy
);
	logic [5:0] s1_q, s2_q, s3_q, lvl_q;
	logic [5:0] s1_d, s2_d, s3_d, lvl_d;

	always_comb
	begin
		s1_d  = s1_q;
		s2_d  = s2_q;
		s3_d  = s3_q;
		lvl_d = lvl_q;
		if (clk_en_i)
		begin
			s1_d = pins_i;
			s2_d = s1_q;
			s3_d = s2_q;
			for (int i = 0; i < 6; i++)
				if (s2_q[i] == s3_q[i])
					lvl_d[i] = s3_q[i];
		end
	end

	// Undriven pins read low: reset to low
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_q  <= 6'h00;
			s2_q  <= 6'h00;
			s3_q  <= 6'h00;
			lvl_q <= 6'h00;
		end
		else
		begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			lvl_q <= lvl_d;
		end
	end

	assign sy.fail_lvl  = lvl_q[0];
	assign sy.ch_lvl    = lvl_q[4:1];
	assign sy.rst_n_lvl = lvl_q[5];
endmodule : slf_in_sync
`default_nettype wire

//--- slf_ctrl_monitor.sv
// Checker of supply-loss and clock-pin relations.
// Bound to slf_ctrl; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module slf_ctrl_monitor
	import slf_pkg::*;
(
	// Clock and reset
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	input wire logic       clk_en_i,
	// Monitors and requests
	input wire logic       wake_i,
	input wire logic       bat_above_por_i,
	input wire logic       vcc_above_por_i,
	input wire logic       gnd_lost_i,
	input wire logic       ext_drv_cfg_i,
	input wire logic       spi_read_req_i,
	// Outputs
	input wire logic       clk_pin_o,
	input wire logic       clk_pin_oe_n_o,
	input wire logic       spi_read_valid_o,
	input wire logic [3:0] power_channel_outputs_o,
	input wire logic       external_driver_control_output_o,
	input wire logic       spi_watchdog_timeout_o,
	input wire logic [1:0] mode_o,
	input wire logic       regs_clear_o
);
	wire logic       bok = bat_above_por_i;
	wire logic       vok = vcc_above_por_i;
	wire logic [3:0] pco = power_channel_outputs_o;
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	power_off_a: assert property (clk_en_i && !bok && !vok |=>
		regs_clear_o && mode_o == SLF_OFF && pco == CH_OFF)
		else $error("power off not clean");
	bat_loss_a: assert property (clk_en_i && !bok |=> pco == CH_OFF)
		else $error("channels on without battery");
	ext_follow_a: assert property (clk_en_i && wake_i && !bok && vok |=>
		external_driver_control_output_o ==
		($past(ext_drv_cfg_i) && mode_o == SLF_NORM))
		else $error("external driver lost setting");
	no_wake_rpt_a: assert property (clk_en_i && !bok |=> clk_pin_oe_n_o)
		else $error("wake reported without battery");
	vcc_wd_a: assert property (clk_en_i && bok && !vok |=>
		spi_watchdog_timeout_o)
		else $error("no timeout on logic supply loss");
	no_read_a: assert property (clk_en_i && !vok && spi_read_req_i |=>
		!spi_read_valid_o)
		else $error("read answered without logic supply");
	gnd_off_a: assert property (clk_en_i && gnd_lost_i |=> pco == CH_OFF)
		else $error("channels on after ground loss");
	clk_high_a: assert property (!clk_pin_oe_n_o |-> clk_pin_o)
		else $error("clock pin driven low");
	sleep_in_a: assert property (clk_en_i && !wake_i |=> clk_pin_oe_n_o)
		else $error("clock pin driven in sleep");
endmodule : slf_ctrl_monitor
bind slf_ctrl slf_ctrl_monitor mon_u (
	.core_clk_i                       (core_clk_i),
	.rst_i                            (rst_i),
	.clk_en_i                         (clk_en_i),
	.wake_i                           (wake_i),
	.bat_above_por_i                  (bat_above_por_i),
	.vcc_above_por_i                  (vcc_above_por_i),
	.gnd_lost_i                       (gnd_lost_i),
	.ext_drv_cfg_i                    (ext_drv_cfg_i),
	.spi_read_req_i                   (spi_read_req_i),
	.clk_pin_o                        (clk_pin_o),
	.clk_pin_oe_n_o                   (clk_pin_oe_n_o),
	.spi_read_valid_o                 (spi_read_valid_o),
	.power_channel_outputs_o          (power_channel_outputs_o),
	.external_driver_control_output_o (external_driver_control_output_o),
	.spi_watchdog_timeout_o           (spi_watchdog_timeout_o),
	.mode_o                           (mode_o),
	.regs_clear_o                     (regs_clear_o)
);
`default_nettype wire

//--- slf_host_model.sv
// Host model: watchdog kicks and discrete pins.
// Bench steers it through request levels.
`timescale 1ns/10ps
`default_nettype none
module slf_host_model (
	// Clock
	input  wire logic       core_clk_i,
	// Requests from the bench
	input  wire logic       kick_i,
	input  wire logic       fail_req_i,
	input  wire logic [3:0] ch_req_i,
	// Pins toward the block
	output logic            frame_o,
	output logic            fail_pin_o,
	output logic [3:0]      ch_pin_o
);
	logic [2:0] cnt_q = 3'h0;
	always @(posedge core_clk_i)
		cnt_q <= #0.5 cnt_q + 3'h1;
	// One valid frame every eight cycles
	assign frame_o = kick_i && cnt_q == 3'h0;
	assign fail_pin_o = fail_req_i;
	// Direct inputs only once fail mode is asked for
	assign ch_pin_o = fail_req_i ? ch_req_i : 4'h0;
endmodule : slf_host_model
`default_nettype wire

//--- slf_ctrl_tb.sv
// Bench for slf_ctrl with the host model on its pins.
// Short deglitch and watchdog counts keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module slf_ctrl_tb
	import slf_pkg::*;
;
	logic        core_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        clk_en_i = 1'b1;
	logic        clk_pin_i = 1'b0;
	logic        wake_i = 1'b1;
	logic        bat_above_por_i = 1'b1;
	logic        vcc_above_por_i = 1'b1;
	logic        gnd_lost_i = 1'b0;
	logic        active_low_reset_pin_i = 1'b0;
	logic        ext_drv_cfg_i = 1'b0;
	logic        watchdog_period_select_i = 1'b0;
	logic        spi_read_req_i = 1'b0;
	logic [3:0]  pwm_ch_i = 4'h0;
	logic [7:0]  fault_flags_i = 8'h0;
	logic [15:0] spi_read_data_i = 16'h0;
	logic        kick = 1'b1;
	logic        freq = 1'b0;
	logic [3:0]  chreq = 4'h0;
	logic [3:0]  held;
	logic        spi_valid_frame_i, fail_mode_force_input_i;
	logic [3:0]  direct_channel_inputs_i, power_channel_outputs_o;
	logic        clk_pin_o, clk_pin_oe_n_o, spi_read_valid_o;
	logic        external_driver_control_output_o, regs_clear_o;
	logic        fail_input_status_bit_o, spi_watchdog_timeout_o;
	logic [15:0] spi_read_data_o;
	logic [7:0]  fault_report_o;
	logic [1:0]  mode_o;
	int          checks = 0;
	int          n_fail = 0;

	localparam int unsigned TB_DGL  = 8;
	localparam int unsigned TB_WD_S = 20;
	localparam int unsigned TB_WD_L = 40;

	slf_ctrl #(
		.DGL_CYCLES (TB_DGL),
		.WD_SHORT   (TB_WD_S),
		.WD_LONG    (TB_WD_L)
	) dut_u (
		.core_clk_i                       (core_clk_i),
		.rst_i                            (rst_i),
		.clk_en_i                         (clk_en_i),
		.wake_i                           (wake_i),
		.bat_above_por_i                  (bat_above_por_i),
		.vcc_above_por_i                  (vcc_above_por_i),
		.gnd_lost_i                       (gnd_lost_i),
		.active_low_reset_pin_i           (active_low_reset_pin_i),
		.fail_mode_force_input_i          (fail_mode_force_input_i),
		.direct_channel_inputs_i          (direct_channel_inputs_i),
		.clk_pin_i                        (clk_pin_i),
		.clk_pin_o                        (clk_pin_o),
		.clk_pin_oe_n_o                   (clk_pin_oe_n_o),
		.pwm_ch_i                         (pwm_ch_i),
		.ext_drv_cfg_i                    (ext_drv_cfg_i),
		.spi_valid_frame_i                (spi_valid_frame_i),
		.watchdog_period_select_i         (watchdog_period_select_i),
		.fault_flags_i                    (fault_flags_i),
		.spi_read_req_i                   (spi_read_req_i),
		.spi_read_data_i                  (spi_read_data_i),
		.spi_read_data_o                  (spi_read_data_o),
		.spi_read_valid_o                 (spi_read_valid_o),
		.power_channel_outputs_o          (power_channel_outputs_o),
		.external_driver_control_output_o (external_driver_control_output_o),
		.fail_input_status_bit_o          (fail_input_status_bit_o),
		.spi_watchdog_timeout_o           (spi_watchdog_timeout_o),
		.fault_report_o                   (fault_report_o),
		.mode_o                           (mode_o),
		.regs_clear_o                     (regs_clear_o)
	);
	slf_host_model host_u (
		.core_clk_i (core_clk_i),
		.kick_i     (kick),
		.fail_req_i (freq),
		.ch_req_i   (chreq),
		.frame_o    (spi_valid_frame_i),
		.fail_pin_o (fail_mode_force_input_i),
		.ch_pin_o   (direct_channel_inputs_i)
	);

	initial
		forever #2.5 core_clk_i = ~core_clk_i;

	// ----
	// Helpers
	// ----
	function automatic logic [3:0] exp_ch(input logic b, input logic g,
		input logic f, input logic [3:0] p, input logic [3:0] d);
		return (!b || g) ? CH_OFF : (f ? d : p);
	endfunction : exp_ch

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
		input string nm);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : cyc

	task automatic tally_and_finish;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// ----
	// Tests
	// ----
	initial
	begin
		void'($urandom(32'h9908));
		cyc(20);
		rst_i = 1'b0;
		cyc(10);
		chk(clk_pin_oe_n_o, 1'b0, "pin oe");
		chk(clk_pin_o, 1'b1, "pin lvl");
		$display("test wake report done");
		for (int i = 0; i < 24; i++)
		begin
			pwm_ch_i = 4'($urandom);
			fault_flags_i = 8'($urandom);
			bat_above_por_i = ($urandom % 4) != 0;
			gnd_lost_i = ($urandom % 4) == 0;
			cyc(1);
			chk(power_channel_outputs_o, exp_ch(bat_above_por_i, gnd_lost_i,
				1'b0, pwm_ch_i, 4'h0), "ch");
			chk(fault_report_o, fault_flags_i, "flt");
		end
		bat_above_por_i = 1'b1;
		gnd_lost_i = 1'b0;
		spi_read_data_i = 16'($urandom);
		spi_read_req_i = 1'b1;
		cyc(1);
		chk(spi_read_data_o, spi_read_data_i, "rdat");
		chk(spi_read_valid_o, 1'b1, "rvld");
		vcc_above_por_i = 1'b0;
		cyc(1);
		spi_read_req_i = 1'b0;
		chk(spi_watchdog_timeout_o, 1'b1, "wd vcc");
		chk(spi_read_valid_o, 1'b0, "rvld vcc");
		chk(spi_read_data_o, 16'h0000, "rdat vcc");
		vcc_above_por_i = 1'b1;
		held = pwm_ch_i;
		clk_en_i = 1'b0;
		pwm_ch_i = ~held;
		cyc(3);
		chk(power_channel_outputs_o, held, "frozen");
		clk_en_i = 1'b1;
		cyc(1);
		chk(power_channel_outputs_o, pwm_ch_i, "thawed");
		$display("test random and read done");
		for (int s = 0; s < 2; s++)
		begin
			watchdog_period_select_i = s[0];
			cyc(12);
			repeat (9) if (!spi_valid_frame_i) cyc(1);
			@(posedge core_clk_i);
			#1 kick = 1'b0;
			cyc(s ? TB_WD_L : TB_WD_S);
			chk(spi_watchdog_timeout_o, 1'b0, "wd early");
			cyc(1);
			chk(spi_watchdog_timeout_o, 1'b1, "wd late");
			kick = 1'b1;
		end
		$display("test watchdog done");
		bat_above_por_i = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			ext_drv_cfg_i = 1'($urandom);
			cyc(1);
			chk(external_driver_control_output_o, ext_drv_cfg_i, "ext");
		end
		vcc_above_por_i = 1'b0;
		cyc(1);
		chk(regs_clear_o, 1'b1, "clr");
		chk(mode_o, SLF_OFF, "off mode");
		bat_above_por_i = 1'b1;
		vcc_above_por_i = 1'b1;
		cyc(10);
		freq = 1'b1;
		chreq = 4'ha;
		cyc(3);
		freq = 1'b0;
		cyc(20);
		chk(mode_o, SLF_NORM, "glitch");
		freq = 1'b1;
		cyc(TB_DGL + 5);
		chk(fail_input_status_bit_o, 1'b1, "stat");
		chk(mode_o, SLF_NORM, "early");
		cyc(1);
		chk(mode_o, SLF_FAIL, "fail");
		vcc_above_por_i = 1'b0;
		chreq = 4'h5;
		cyc(20);
		chk(power_channel_outputs_o, exp_ch(1'b1, 1'b0, 1'b1, pwm_ch_i,
			chreq), "direct");
		freq = 1'b0;
		vcc_above_por_i = 1'b1;
		cyc(12);
		chk(fail_input_status_bit_o, 1'b0, "stat lo");
		$display("test fail mode done");
		wake_i = 1'b0;
		cyc(2);
		chk(mode_o, SLF_SLEEP, "sleep");
		chk(power_channel_outputs_o, CH_OFF, "sleep ch");
		active_low_reset_pin_i = 1'b1;
		cyc(8);
		wake_i = 1'b1;
		cyc(8);
		chk(clk_pin_oe_n_o, 1'b1, "pin wake");
		active_low_reset_pin_i = 1'b0;
		cyc(8);
		chk(clk_pin_oe_n_o, 1'b1, "pin rst wake");
		wake_i = 1'b0;
		cyc(2);
		wake_i = 1'b1;
		cyc(2);
		chk(clk_pin_oe_n_o, 1'b0, "pin rewake");
		$display("test sleep done");
		tally_and_finish();
	end

	initial
	begin
		repeat (4000) @(posedge core_clk_i);
		n_fail++;
		tally_and_finish();
	end
endmodule : slf_ctrl_tb
`default_nettype wire
